// *** src/srsl_status.sv ***
// status byte, service request mask and bus addressing of the instrument
// assumes command strobes are one-cycle pulses from the bus parser
//
// Functional notes
// - the clear-status command empties both event registers and so their summaries, keeping only events set in that same cycle.
// - clear-status leaves the output buffer, measurement-done flag and MAV alone.
// - an eight-bit mask holds one enable per status byte position other than bit 6, which always stays zero.
// - an enabled high summary message raises a request for service.
// - the mask query returns the set bits' weighted sum with bit 6 always zero.
// - a mask write of zero clears every mask bit.
// - a power-on transition clears the mask only while the power-on clear flag is set.
// - interface clear stops talking and listening and leaves the device unaddressed.
// - interface clear changes neither the request for service nor the status byte.
// - results go out as numeric or block data and status as character data.
// - bit 6 is the OR of the other seven status bits ANDed with their mask bits.
// - bit 4 shows message available and is low when the output buffer is empty.
// - bit 5 is the OR of standard events ANDed with their enables.
`timescale 1ns/1ps
`default_nettype none

module srsl_status (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  input  wire logic       POWER_ON,
  input  wire logic       PSC_FLAG,
  input  wire logic       CLS_CMD,
  input  wire logic       MASK_WR,
  input  wire logic [7:0] MASK_WDATA,
  input  wire logic       MASK_QUERY,
  input  wire logic       STB_QUERY,
  input  wire logic       SERIAL_POLL,
  input  wire logic [7:0] HW_EVENT,
  input  wire logic [7:0] HW_ENABLE,
  input  wire logic [7:0] STD_EVENT,
  input  wire logic [7:0] STD_ENABLE,
  input  wire logic       OUTBUF_NOT_EMPTY,
  input  wire logic       MEASUREMENT_DONE_FLAG,
  input  wire logic       IFC,
  input  wire logic       MY_LISTEN_ADDR,
  input  wire logic       MY_TALK_ADDR,
  input  wire logic       UNADDRESS,
  input  wire logic       RESULT_SEND,
  input  wire logic       RESULT_BLOCK,
  output logic      [7:0] SERVICE_REQUEST_MASK,
  output logic      [7:0] RSP_DATA,
  output logic            RSP_VALID,
  output logic      [1:0] OUT_TYPE,
  output logic            OUT_TYPE_VALID,
  output logic            TALK_ACTIVE,
  output logic            LISTEN_ACTIVE,
  output logic            SRQ_OUT,
  output logic            SRQ_OE_N
);

  srsl_pkg::srsl_state_t st;
  srsl_pkg::srsl_state_t next_st;

  logic [7:0] hw_ev;
  logic [7:0] std_ev;
  logic       hsb;
  logic       esb;
  logic [7:0] stb_low;
  logic       mss;
  logic [7:0] stb;
  logic       mss_rise;

  // ----------------------------------------------------------------
  // event registers
  // ----------------------------------------------------------------
  srsl_event_reg u_hw_events (
    .clk     (SYS_CLK),
    .reset   (RESET),
    .set_ev  (HW_EVENT),
    .clr     (CLS_CMD),
    .enable  (HW_ENABLE),
    .ev      (hw_ev),
    .summary (hsb)
  );

  srsl_event_reg u_std_events (
    .clk     (SYS_CLK),
    .reset   (RESET),
    .set_ev  (STD_EVENT),
    .clr     (CLS_CMD),
    .enable  (STD_ENABLE),
    .ev      (std_ev),
    .summary (esb)
  );

  // ----------------------------------------------------------------
  // status byte
  // ----------------------------------------------------------------
  always_comb begin
    stb_low                         = srsl_pkg::SRSL_BYTE_ZERO;
    stb_low[srsl_pkg::SRSL_HSB_BIT] = hsb;
    stb_low[srsl_pkg::SRSL_MDF_BIT] = MEASUREMENT_DONE_FLAG;
    stb_low[srsl_pkg::SRSL_MAV_BIT] = OUTBUF_NOT_EMPTY;
    stb_low[srsl_pkg::SRSL_ESB_BIT] = esb;
  end

  assign mss      = srsl_pkg::srsl_summary(stb_low, st.mask);
  assign mss_rise = mss & ~st.mss_d;

  always_comb begin
    stb                             = stb_low;
    stb[srsl_pkg::SRSL_MSS_BIT]     = mss;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.mss_d   = mss;
    next_st.rsp_v   = 1'b0;
    next_st.otype_v = 1'b0;

    // request for service: poll clears, new reason sets and wins
    if (SERIAL_POLL) begin
      next_st.rqs = 1'b0;
    end
    if (mss_rise) begin
      next_st.rqs = 1'b1;
    end

    // mask: write has priority over the power-on clear
    if (POWER_ON && PSC_FLAG) begin
      next_st.mask = srsl_pkg::SRSL_MASK_RESET;
    end
    if (MASK_WR) begin
      next_st.mask = MASK_WDATA & srsl_pkg::SRSL_MASK_WRITABLE;
    end

    // one answer per cycle: poll, then status query, then mask query
    if (SERIAL_POLL) begin
      next_st.rsp                         = stb_low;
      next_st.rsp[srsl_pkg::SRSL_MSS_BIT] = st.rqs;
      next_st.rsp_v                       = 1'b1;
    end else if (STB_QUERY) begin
      next_st.rsp     = stb;
      next_st.rsp_v   = 1'b1;
      next_st.otype   = srsl_pkg::SRSL_TYPE_CHAR;
      next_st.otype_v = 1'b1;
    end else if (MASK_QUERY) begin
      next_st.rsp     = st.mask & srsl_pkg::SRSL_MASK_WRITABLE;
      next_st.rsp_v   = 1'b1;
      next_st.otype   = srsl_pkg::SRSL_TYPE_CHAR;
      next_st.otype_v = 1'b1;
    end else if (RESULT_SEND && st.bus == srsl_pkg::SRSL_TALK && !IFC) begin
      next_st.otype   = RESULT_BLOCK ? srsl_pkg::SRSL_TYPE_BLOCK
                                     : srsl_pkg::SRSL_TYPE_NUMERIC;
      next_st.otype_v = 1'b1;
    end

    // addressing
    case (st.bus)
      srsl_pkg::SRSL_IDLE: begin
        if (MY_TALK_ADDR) begin
          next_st.bus = srsl_pkg::SRSL_TALK;
        end else if (MY_LISTEN_ADDR) begin
          next_st.bus = srsl_pkg::SRSL_LISTEN;
        end
      end
      srsl_pkg::SRSL_LISTEN: begin
        if (MY_TALK_ADDR) begin
          next_st.bus = srsl_pkg::SRSL_TALK;
        end else if (UNADDRESS) begin
          next_st.bus = srsl_pkg::SRSL_IDLE;
        end
      end
      srsl_pkg::SRSL_TALK: begin
        if (MY_LISTEN_ADDR) begin
          next_st.bus = srsl_pkg::SRSL_LISTEN;
        end else if (UNADDRESS) begin
          next_st.bus = srsl_pkg::SRSL_IDLE;
        end
      end
      default: begin
        next_st.bus = srsl_pkg::SRSL_IDLE;
      end
    endcase
    // interface clear forces addressing idle and holds off a result send
    if (IFC) begin
      next_st.bus = srsl_pkg::SRSL_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st.mask    <= srsl_pkg::SRSL_MASK_RESET;
      st.rqs     <= 1'b0;
      st.mss_d   <= 1'b0;
      st.bus     <= srsl_pkg::SRSL_IDLE;
      st.rsp     <= srsl_pkg::SRSL_BYTE_ZERO;
      st.rsp_v   <= 1'b0;
      st.otype   <= srsl_pkg::SRSL_TYPE_NONE;
      st.otype_v <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SERVICE_REQUEST_MASK = st.mask;
  assign RSP_DATA             = st.rsp;
  assign RSP_VALID            = st.rsp_v;
  assign OUT_TYPE             = st.otype;
  assign OUT_TYPE_VALID       = st.otype_v;
  assign TALK_ACTIVE          = (st.bus == srsl_pkg::SRSL_TALK);
  assign LISTEN_ACTIVE        = (st.bus == srsl_pkg::SRSL_LISTEN);
  assign SRQ_OUT              = 1'b0;
  assign SRQ_OE_N             = ~st.rqs;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cls_quiet;
    CLS_CMD && HW_EVENT == srsl_pkg::SRSL_BYTE_ZERO && STD_EVENT == srsl_pkg::SRSL_BYTE_ZERO;
  endsequence

  sequence s_poll_no_rise;
    SERIAL_POLL && !mss_rise;
  endsequence

  a_cls_clears_events: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    s_cls_quiet |=> (hw_ev == srsl_pkg::SRSL_BYTE_ZERO && std_ev == srsl_pkg::SRSL_BYTE_ZERO
                     && !hsb && !esb))
    else $error("clear-status left an event set");

  a_cls_keeps_mav: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    CLS_CMD && OUTBUF_NOT_EMPTY && MEASUREMENT_DONE_FLAG
      |-> stb[srsl_pkg::SRSL_MAV_BIT] && stb[srsl_pkg::SRSL_MDF_BIT])
    else $error("clear-status disturbed mav or done flag");

  a_mask_bit6_zero: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    MASK_WR |=> SERVICE_REQUEST_MASK == (($past(MASK_WDATA)) & srsl_pkg::SRSL_MASK_WRITABLE))
    else $error("mask write stored wrong value");

  a_rqs_raised: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    mss_rise |=> !SRQ_OE_N)
    else $error("enabled summary gave no service request");

  a_query_mask: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    MASK_QUERY && !SERIAL_POLL && !STB_QUERY
      |=> RSP_VALID && RSP_DATA == $past(SERVICE_REQUEST_MASK) && !RSP_DATA[srsl_pkg::SRSL_MSS_BIT])
    else $error("mask query answer wrong");

  a_zero_write_clears: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    MASK_WR && MASK_WDATA == srsl_pkg::SRSL_BYTE_ZERO
      |=> SERVICE_REQUEST_MASK == srsl_pkg::SRSL_BYTE_ZERO)
    else $error("zero write left mask bits");

  a_psc_clear: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    POWER_ON && PSC_FLAG && !MASK_WR |=> SERVICE_REQUEST_MASK == srsl_pkg::SRSL_MASK_RESET)
    else $error("power-on with clear flag kept the mask");

  a_psc_keep: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    POWER_ON && !PSC_FLAG && !MASK_WR |=> $stable(SERVICE_REQUEST_MASK))
    else $error("power-on without clear flag changed the mask");

  a_ifc_unaddress: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    IFC |=> !TALK_ACTIVE && !LISTEN_ACTIVE)
    else $error("interface clear left device addressed");

  a_ifc_keeps_rqs: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    IFC && !SERIAL_POLL && !mss_rise |=> $stable(SRQ_OE_N))
    else $error("interface clear changed the service request");

  a_status_char: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    STB_QUERY && !SERIAL_POLL |=> OUT_TYPE_VALID && OUT_TYPE == srsl_pkg::SRSL_TYPE_CHAR)
    else $error("status not sent as character data");

  a_mss_relation: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    STB_QUERY && !SERIAL_POLL
      |=> RSP_DATA[srsl_pkg::SRSL_MSS_BIT] == |($past(stb_low) & $past(SERVICE_REQUEST_MASK)))
    else $error("master summary bit wrong in status answer");

  a_mav_low: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    !OUTBUF_NOT_EMPTY |-> !stb[srsl_pkg::SRSL_MAV_BIT])
    else $error("mav high with empty buffer");

  a_poll_releases: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    s_poll_no_rise |=> SRQ_OE_N && RSP_VALID
      && RSP_DATA[srsl_pkg::SRSL_MSS_BIT] == !$past(SRQ_OE_N)
      ##1 (!RSP_VALID || $past(SERIAL_POLL || STB_QUERY || MASK_QUERY)))
    else $error("serial poll did not free the request line");

endmodule

`default_nettype wire

// *** inc/srsl_pkg.sv ***
// package for the service request status logic
// assumes one 20 MHz clock and a single async reset
package srsl_pkg;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned SRSL_HSB_BIT = 0;
  localparam int unsigned SRSL_MDF_BIT = 1;
  localparam int unsigned SRSL_MAV_BIT = 4;
  localparam int unsigned SRSL_ESB_BIT = 5;
  localparam int unsigned SRSL_MSS_BIT = 6;

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------
  localparam logic [7:0] SRSL_MASK_RESET    = 8'h00;
  localparam logic [7:0] SRSL_MASK_WRITABLE = 8'hBF;
  localparam logic [7:0] SRSL_EVENT_RESET   = 8'h00;
  localparam logic [7:0] SRSL_BYTE_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // output data type codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRSL_TYPE_NONE    = 2'h0;
  localparam logic [1:0] SRSL_TYPE_NUMERIC = 2'h1;
  localparam logic [1:0] SRSL_TYPE_BLOCK   = 2'h2;
  localparam logic [1:0] SRSL_TYPE_CHAR    = 2'h3;

  // ----------------------------------------------------------------
  // bus addressing states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRSL_IDLE   = 3'h1,
    SRSL_LISTEN = 3'h2,
    SRSL_TALK   = 3'h4
  } srsl_bus_t;

  typedef struct packed {
    logic [7:0] mask;
    logic       rqs;
    logic       mss_d;
    srsl_bus_t  bus;
    logic [7:0] rsp;
    logic       rsp_v;
    logic [1:0] otype;
    logic       otype_v;
  } srsl_state_t;

  typedef struct packed {
    logic [7:0] ev;
  } srsl_evreg_t;

  // OR of a vector ANDed with its enables
  function automatic logic srsl_summary(input logic [7:0] vec, input logic [7:0] en);
    return |(vec & en);
  endfunction

endpackage

// *** src/srsl_event_reg.sv ***
// sticky 8-bit event register with enable summary
// assumes event pulses and clear pulses synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module srsl_event_reg (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] set_ev,
  input  wire logic       clr,
  input  wire logic [7:0] enable,
  output logic      [7:0] ev,
  output logic            summary
);

  srsl_pkg::srsl_evreg_t st;
  srsl_pkg::srsl_evreg_t next_st;

  // set wins over a clear in the same cycle
  always_comb begin
    next_st = st;
    if (clr) begin
      next_st.ev = srsl_pkg::SRSL_EVENT_RESET;
    end
    next_st.ev = next_st.ev | set_ev;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.ev <= srsl_pkg::SRSL_EVENT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign ev      = st.ev;
  assign summary = srsl_pkg::srsl_summary(st.ev, enable);

endmodule

`default_nettype wire

// *** verif/srsl_ctl_model.sv ***
// bus controller model: issues commands to the status logic, keeps answers
// assumes go is a one-cycle pulse from the bench, clk is the system clock
`timescale 1ns/1ps
`default_nettype none

module srsl_ctl_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] op,
  input  wire logic [7:0] val,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  output logic            cls_cmd,
  output logic            mask_wr,
  output logic      [7:0] mask_wdata,
  output logic            mask_query,
  output logic            stb_query,
  output logic            serial_poll,
  output logic      [7:0] rsp_seen
);
  // ----------------------------------------------------------------
  // command strobes, one cycle each
  // ----------------------------------------------------------------
  initial begin
    {cls_cmd, mask_wr, mask_query, stb_query, serial_poll} = 5'h00;
    mask_wdata = 8'h00;
    rsp_seen  = 8'h00;
  end

  always @(posedge clk) begin
    cls_cmd     <= go && op == 3'h0;
    mask_wr     <= go && op == 3'h1;
    mask_query  <= go && op == 3'h2;
    stb_query   <= go && op == 3'h3;
    serial_poll <= go && op == 3'h4;
    // argument is the weighted sum; idle data toggles
    mask_wdata  <= (go && op == 3'h1) ? val : ~mask_wdata;
    if (rsp_valid) begin
      rsp_seen <= rsp_data;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_srsl_status.sv ***
// self-checking bench of the status logic
// assumes a controller model on the command side, all else driven here
`timescale 1ns/1ps
`default_nettype none

module tb_srsl_status;
  logic       sys_clk, reset, power_on, psc_flag, go, mask_query, stb_query;
  logic       serial_poll, outbuf, done, ifc, talk_a, listen_a, unaddr, res_send;
  logic       res_block, cls_cmd, mask_wr, rsp_valid, otv, talk, listen, srq, oe_n;
  logic [2:0] op;
  logic [7:0] val, mask_wdata, hw_event, hw_enable, std_event, std_enable;
  logic [7:0] mask, rsp_data, rsp_seen, v;
  logic [1:0] out_type;
  int         err_count, n_tests, i;

  srsl_status i_srsl_status (.SYS_CLK(sys_clk), .RESET(reset), .POWER_ON(power_on),
    .PSC_FLAG(psc_flag), .CLS_CMD(cls_cmd), .MASK_WR(mask_wr), .MASK_WDATA(mask_wdata),
    .MASK_QUERY(mask_query), .STB_QUERY(stb_query), .SERIAL_POLL(serial_poll),
    .HW_EVENT(hw_event), .HW_ENABLE(hw_enable), .STD_EVENT(std_event),
    .STD_ENABLE(std_enable), .OUTBUF_NOT_EMPTY(outbuf), .MEASUREMENT_DONE_FLAG(done),
    .IFC(ifc), .MY_LISTEN_ADDR(listen_a), .MY_TALK_ADDR(talk_a), .UNADDRESS(unaddr),
    .RESULT_SEND(res_send), .RESULT_BLOCK(res_block), .SERVICE_REQUEST_MASK(mask),
    .RSP_DATA(rsp_data), .RSP_VALID(rsp_valid), .OUT_TYPE(out_type),
    .OUT_TYPE_VALID(otv), .TALK_ACTIVE(talk), .LISTEN_ACTIVE(listen), .SRQ_OUT(srq),
    .SRQ_OE_N(oe_n));

  srsl_ctl_model i_srsl_ctl_model (.clk(sys_clk), .go(go), .op(op), .val(val),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cls_cmd(cls_cmd), .mask_wr(mask_wr),
    .mask_wdata(mask_wdata), .mask_query(mask_query), .stb_query(stb_query),
    .serial_poll(serial_poll), .rsp_seen(rsp_seen));

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_stb(input logic hw, dn, mv, sd, input logic [7:0] m);
    logic [7:0] s;
    s = {2'h0, sd, mv, 2'h0, dn, hw};
    return s | {1'h0, |(s & m & 8'hBF), 6'h00};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [2:0] o, input logic [7:0] d);
    @(posedge sys_clk);
    go  <= 1'h1;
    op  <= o;
    val <= d;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic pin(input int k);
    @(posedge sys_clk);
    case (k)
      0: power_on <= 1'h1;
      1: talk_a   <= 1'h1;
      2: listen_a <= 1'h1;
      3: unaddr   <= 1'h1;
      4: res_send <= 1'h1;
      default: ifc <= 1'h1;
    endcase
    @(posedge sys_clk);
    {power_on, talk_a, listen_a, unaddr, res_send, ifc} <= 6'h00;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic ev(input logic [7:0] h, input logic [7:0] s);
    @(posedge sys_clk);
    hw_event  <= h;
    std_event <= s;
    @(posedge sys_clk);
    hw_event  <= 8'h00;
    std_event <= 8'h00;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #(3000 * 50);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {sys_clk, power_on, psc_flag, go, outbuf, done, ifc, talk_a, listen_a} = 9'h000;
    {unaddr, res_send, res_block} = 3'h0;
    {op, val, hw_event, hw_enable, std_event, std_enable} = 43'h0;
    err_count = 0;
    n_tests   = 0;
    reset     = 1'h1;
    void'($urandom(32'h3bfe));
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    #1;
    chk(mask, 8'h00);
    chk({7'h00, oe_n}, 8'h01);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      cmd(3'h1, v);
      chk(mask, v & 8'hBF);
      cmd(3'h2, 8'h00);
      chk(rsp_seen, v & 8'hBF);
      chk({6'h00, out_type}, 8'h03);
    end
    cmd(3'h1, 8'h00);
    chk(mask, 8'h00);
    $display("test mask done");
    cmd(3'h1, 8'h21);
    pin(0);
    chk(mask, 8'h21);
    @(posedge sys_clk) psc_flag <= 1'h1;
    pin(0);
    chk(mask, 8'h00);
    $display("test power on done");
    @(posedge sys_clk);
    outbuf <= 1'h1;
    done   <= 1'h1;
    cmd(3'h1, 8'h10);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h00, srq, oe_n}, 8'h00);
    cmd(3'h3, 8'h00);
    chk(rsp_seen, exp_stb(1'h0, 1'h1, 1'h1, 1'h0, 8'h10));
    cmd(3'h4, 8'h00);
    chk(rsp_seen, 8'h52);
    chk({7'h00, oe_n}, 8'h01);
    cmd(3'h4, 8'h00);
    chk(rsp_seen, 8'h12);
    $display("test service request done");
    v = 8'($urandom_range(1, 255));
    @(posedge sys_clk);
    hw_enable  <= 8'h08;
    std_enable <= v;
    ev(8'h08, v);
    cmd(3'h1, 8'h21);
    cmd(3'h3, 8'h00);
    chk(rsp_seen, exp_stb(1'h1, 1'h1, 1'h1, 1'h1, 8'h21));
    cmd(3'h0, 8'h00);
    cmd(3'h3, 8'h00);
    chk(rsp_seen, exp_stb(1'h0, 1'h1, 1'h1, 1'h0, 8'h21));
    @(posedge sys_clk) outbuf <= 1'h0;
    cmd(3'h3, 8'h00);
    chk(rsp_seen, exp_stb(1'h0, 1'h1, 1'h0, 1'h0, 8'h21));
    $display("test events done");
    cmd(3'h1, 8'h01);
    ev(8'h08, 8'h00);
    pin(1);
    chk({7'h00, talk}, 8'h01);
    @(posedge sys_clk) res_block <= 1'h1;
    pin(4);
    chk({6'h00, out_type}, 8'h02);
    @(posedge sys_clk) res_block <= 1'h0;
    pin(4);
    chk({6'h00, out_type}, 8'h01);
    pin(2);
    pin(5);
    chk({6'h00, talk, listen}, 8'h00);
    chk({7'h00, oe_n}, 8'h00);
    cmd(3'h3, 8'h00);
    chk(rsp_seen, exp_stb(1'h1, 1'h1, 1'h0, 1'h0, 8'h01));
    pin(4);
    chk({6'h00, out_type}, 8'h03);
    pin(2);
    chk({7'h00, listen}, 8'h01);
    pin(3);
    chk({7'h00, listen}, 8'h00);
    $display("test bus done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
